// File: rtl/cpm_regs.sv
// cpm_regs: post-charge configuration register and first monitor register
// assumes a serial-bus front end issuing one-cycle read/write strobes
`timescale 1ns/100ps
`default_nettype none
module cpm_regs
  import cpm_pkg::*;
#(
  parameter logic [31:0] P_LOAD_SHORT_CYC = CPM_LOAD_SHORT_CYC,
  parameter logic [31:0] P_LOAD_MID_CYC = CPM_LOAD_MID_CYC,
  parameter logic [31:0] P_LOAD_LONG_CYC = CPM_LOAD_LONG_CYC,
  parameter logic [31:0] P_LOAD_PERIOD_CYC = CPM_LOAD_PERIOD_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_term_current_cmp,
  input wire logic i_battery_voltage_cmp,
  input wire logic i_linear_precharge_active,
  input wire logic i_die_over_temp,
  input wire logic i_charge_loop_active_n,
  input wire logic i_input_loop_active_n,
  input wire logic i_input_supply_qualified,
  input wire logic i_float_voltage_loop_flag,
  input wire logic i_thermistor_out_of_range,
  input wire logic i_charging,
  input wire logic i_charge_done,
  input wire logic i_prod_mode,
  input wire logic [7:0] i_test_reg_value,
  output logic o_absent_detect,
  output logic o_input_load_on,
  output logic o_background_charge_on,
  output logic [2:0] o_background_term_current,
  output logic o_charge_current_cap
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire logic hit_cfg = (i_reg_addr == CPM_ADDR_POST_CFG);
  wire logic hit_mon = (i_reg_addr == CPM_ADDR_MONITOR_A);
  wire logic cfg_wr = i_reg_wr && hit_cfg;

  // ----------------------------------------------------------------------
  // post-charge configuration register
  // ----------------------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;

  assign cfg_next = cfg_wr ? i_reg_wdata : cfg_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cfg_reg <= CPM_POST_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  wire cpm_policy_e absent_detect_policy =
    cpm_policy_e'(cfg_reg[CPM_POLICY_MSB:CPM_POLICY_LSB]);
  wire cpm_load_e input_load_pulse_sel =
    cpm_load_e'(cfg_reg[CPM_LOAD_MSB:CPM_LOAD_LSB]);
  assign o_background_charge_on = cfg_reg[CPM_BG_ON_BIT];
  assign o_background_term_current =
    cfg_reg[CPM_TERM_MSB:CPM_TERM_LSB];

  // ----------------------------------------------------------------------
  // battery-absent detection policy
  // ----------------------------------------------------------------------
  wire logic test_key_set = (i_test_reg_value == CPM_TEST_KEY);
  wire logic oor_event = i_thermistor_out_of_range &&
                         (i_charging || i_charge_done);
  wire logic policy_allows =
    (absent_detect_policy == CPM_POLICY_ALWAYS) ? 1'b1 :
    (absent_detect_policy == CPM_POLICY_NO_NORMAL) ? i_prod_mode :
    (absent_detect_policy == CPM_POLICY_NO_TEST) ? !test_key_set :
    !i_charge_done;
  logic absent_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      absent_reg <= 1'b0;
    end else begin
      absent_reg <= oor_event && policy_allows;
    end
  end

  assign o_absent_detect = absent_reg;

  // ----------------------------------------------------------------------
  // charge-done input loading
  // ----------------------------------------------------------------------
  wire logic load_en = i_charge_done &&
                       (input_load_pulse_sel != CPM_LOAD_NONE);
  wire logic [31:0] load_len =
    (input_load_pulse_sel == CPM_LOAD_SHORT) ? P_LOAD_SHORT_CYC :
    (input_load_pulse_sel == CPM_LOAD_MID) ? P_LOAD_MID_CYC :
    P_LOAD_LONG_CYC;

  cpm_load_timer u_load_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_enable(load_en),
    .i_pulse_cycles(load_len),
    .i_period_cycles(P_LOAD_PERIOD_CYC),
    .o_load_on(o_input_load_on)
  );

  // ----------------------------------------------------------------------
  // thermal current cap
  // ----------------------------------------------------------------------
  logic cap_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cap_reg <= 1'b0;
    end else begin
      cap_reg <= i_die_over_temp;
    end
  end

  assign o_charge_current_cap = cap_reg;

  // ----------------------------------------------------------------------
  // monitor word and read path
  // ----------------------------------------------------------------------
  wire logic [7:0] mon_word;

  assign mon_word[CPM_MON_TERM_BIT] = i_term_current_cmp;
  assign mon_word[CPM_MON_VBAT_BIT] = i_battery_voltage_cmp;
  assign mon_word[CPM_MON_LIN_BIT] = i_linear_precharge_active;
  assign mon_word[CPM_MON_HOT_BIT] = i_die_over_temp;
  assign mon_word[CPM_MON_CHG_LOOP_BIT] = i_charge_loop_active_n;
  assign mon_word[CPM_MON_IN_LOOP_BIT] = i_input_loop_active_n;
  assign mon_word[CPM_MON_QUAL_BIT] = i_input_supply_qualified;
  assign mon_word[CPM_MON_CV_BIT] = i_float_voltage_loop_flag;

  wire logic [7:0] rd_mux = hit_cfg ? cfg_reg :
                            hit_mon ? mon_word :
                            CPM_UNMAPPED_RD;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  assign rdata_next = i_reg_rd ? rd_mux : rdata_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_reg <= CPM_UNMAPPED_RD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_reg_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_policy_always;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (absent_detect_policy == CPM_POLICY_ALWAYS) && oor_event
      |=> o_absent_detect;
  endproperty
  a_policy_always: assert property (p_policy_always)
    else $error("absent detect missed with policy 00");

  property p_policy_normal;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (absent_detect_policy == CPM_POLICY_NO_NORMAL) && !i_prod_mode
      |=> !o_absent_detect;
  endproperty
  a_policy_normal: assert property (p_policy_normal)
    else $error("absent detect in normal mode with policy 01");

  property p_policy_test;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (absent_detect_policy == CPM_POLICY_NO_TEST) && test_key_set
      |=> !o_absent_detect;
  endproperty
  a_policy_test: assert property (p_policy_test)
    else $error("absent detect while test key set with policy 10");

  property p_policy_done;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (absent_detect_policy == CPM_POLICY_NO_DONE) && i_charge_done
      |=> !o_absent_detect;
  endproperty
  a_policy_done: assert property (p_policy_done)
    else $error("absent detect in charge done with policy 11");

  property p_load_off;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_charge_done || (input_load_pulse_sel == CPM_LOAD_NONE)
      |=> !o_input_load_on;
  endproperty
  a_load_off: assert property (p_load_off)
    else $error("input load outside charge done or with code 00");

  property p_load_start;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(load_en) |=> o_input_load_on;
  endproperty
  a_load_start: assert property (p_load_start)
    else $error("load pulse did not start with charge done");

  property p_cfg_reset;
    @(posedge i_sys_clk)
    !i_rst_n |=> (cfg_reg == CPM_POST_CFG_RST) && !o_background_charge_on;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("config register reset value wrong");

  property p_cfg_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    cfg_wr ##1 !i_reg_wr ##1 (i_reg_rd && hit_cfg && !i_reg_wr)
      |=> o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config readback differs from written value");

  property p_mon_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reg_rd && hit_mon |=>
      o_reg_rdata[CPM_MON_HOT_BIT] == $past(i_die_over_temp) &&
      o_reg_rdata[CPM_MON_CHG_LOOP_BIT] == $past(i_charge_loop_active_n);
  endproperty
  a_mon_read: assert property (p_mon_read)
    else $error("monitor read does not reflect live status");

  property p_cap;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_die_over_temp |=> o_charge_current_cap;
  endproperty
  a_cap: assert property (p_cap)
    else $error("charge current cap missing above die limit");

endmodule : cpm_regs
`default_nettype wire

// File: shared/cpm_pkg.sv
// cpm_pkg: constants and types for the post-charge config and monitor regs
// assumes a 250 MHz device clock and an 8-bit register address space
`default_nettype none
package cpm_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CPM_ADDR_POST_CFG = 8'h07;
  localparam logic [7:0] CPM_ADDR_MONITOR_A = 8'h10;
  localparam logic [7:0] CPM_POST_CFG_RST = 8'h01;
  localparam logic [7:0] CPM_UNMAPPED_RD = 8'h00;

  // ----------------------------------------------------------------------
  // post-charge config field positions
  // ----------------------------------------------------------------------
  localparam int CPM_POLICY_MSB = 7;
  localparam int CPM_POLICY_LSB = 6;
  localparam int CPM_LOAD_MSB = 5;
  localparam int CPM_LOAD_LSB = 4;
  localparam int CPM_BG_ON_BIT = 3;
  localparam int CPM_TERM_MSB = 2;
  localparam int CPM_TERM_LSB = 0;

  // ----------------------------------------------------------------------
  // monitor bit positions
  // ----------------------------------------------------------------------
  localparam int CPM_MON_TERM_BIT = 7;
  localparam int CPM_MON_VBAT_BIT = 6;
  localparam int CPM_MON_LIN_BIT = 5;
  localparam int CPM_MON_HOT_BIT = 4;
  localparam int CPM_MON_CHG_LOOP_BIT = 3;
  localparam int CPM_MON_IN_LOOP_BIT = 2;
  localparam int CPM_MON_QUAL_BIT = 1;
  localparam int CPM_MON_CV_BIT = 0;

  // ----------------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CPM_POLICY_ALWAYS = 2'b00,
    CPM_POLICY_NO_NORMAL = 2'b01,
    CPM_POLICY_NO_TEST = 2'b10,
    CPM_POLICY_NO_DONE = 2'b11
  } cpm_policy_e;

  typedef enum logic [1:0] {
    CPM_LOAD_NONE = 2'b00,
    CPM_LOAD_SHORT = 2'b01,
    CPM_LOAD_MID = 2'b10,
    CPM_LOAD_LONG = 2'b11
  } cpm_load_e;

  localparam logic [7:0] CPM_TEST_KEY = 8'hB5;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CPM_CLK_KHZ = 250000;
  localparam int CPM_LOAD_SHORT_MS = 4;
  localparam int CPM_LOAD_MID_MS = 131;
  localparam int CPM_LOAD_LONG_MS = 135;
  localparam int CPM_LOAD_PERIOD_MS = 1000;
  localparam logic [31:0] CPM_LOAD_SHORT_CYC =
    32'(CPM_LOAD_SHORT_MS * CPM_CLK_KHZ);
  localparam logic [31:0] CPM_LOAD_MID_CYC =
    32'(CPM_LOAD_MID_MS * CPM_CLK_KHZ);
  localparam logic [31:0] CPM_LOAD_LONG_CYC =
    32'(CPM_LOAD_LONG_MS * CPM_CLK_KHZ);
  localparam logic [31:0] CPM_LOAD_PERIOD_CYC =
    32'(CPM_LOAD_PERIOD_MS * CPM_CLK_KHZ);
  localparam logic [31:0] CPM_CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] CPM_CNT_ONE = 32'h0000_0001;

endpackage : cpm_pkg
`default_nettype wire

// File: rtl/cpm_load_timer.sv
// cpm_load_timer: periodic input-supply load pulse generator
// assumes pulse length below period; enable low drops the registered pulse one clock later
`timescale 1ns/100ps
`default_nettype none
module cpm_load_timer
  import cpm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [31:0] i_pulse_cycles,
  input wire logic [31:0] i_period_cycles,
  output logic o_load_on
);

  // ----------------------------------------------------------------------
  // period counter and pulse window
  // ----------------------------------------------------------------------
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic load_reg;
  logic load_next;
  wire logic wrap = (cnt_reg >= i_period_cycles - CPM_CNT_ONE);

  assign cnt_next = !i_enable ? CPM_CNT_ZERO :
                    wrap ? CPM_CNT_ZERO : cnt_reg + CPM_CNT_ONE;
  assign load_next = i_enable && (cnt_reg < i_pulse_cycles);
  assign o_load_on = load_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= CPM_CNT_ZERO;
      load_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      load_reg <= load_next;
    end
  end

endmodule : cpm_load_timer
`default_nettype wire

// File: tb/cpm_host_model.sv
// cpm_host_model: host side of the register port, byte reads and writes
// assumes strobes are sampled on the rising edge, rdata one cycle later
`timescale 1ns/100ps
`default_nettype none
module cpm_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // ---------------------------------------------------------------------
  // bus tasks, released lines show the inverse of the last value
  // ---------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_sys_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_sys_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask : rd
endmodule : cpm_host_model
`default_nettype wire

// File: tb/charger_postcharge_monitor_regs_tb_top.sv
// testbench: random config and status traffic with load pulse corners
// assumes cpm_regs with shortened load pulse and period parameters
`timescale 1ns/100ps
`default_nettype none
module charger_postcharge_monitor_regs_tb_top;
  import cpm_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata, rd_v, cfg, cnt;
  logic wr, rd, absent, load_on, bg_on, cap;
  logic [2:0] bg_term;
  logic [7:0] st = 8'h00;
  logic [7:0] test_val = 8'h00;
  logic [15:0] r;
  logic oor = 1'b0, charging = 1'b0, done = 1'b0, prod = 1'b0;
  integer seed = 45;
  int mismatches = 0;
  int checked = 0;
  int n;
  always #2 i_sys_clk = ~i_sys_clk;
  cpm_host_model u_host (.i_sys_clk(i_sys_clk), .i_rdata(rdata),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  cpm_regs #(.P_LOAD_SHORT_CYC(32'h0000_0004),
    .P_LOAD_MID_CYC(32'h0000_0008), .P_LOAD_LONG_CYC(32'h0000_0009),
    .P_LOAD_PERIOD_CYC(32'h0000_0014)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_term_current_cmp(st[7]),
    .i_battery_voltage_cmp(st[6]), .i_linear_precharge_active(st[5]),
    .i_die_over_temp(st[4]), .i_charge_loop_active_n(st[3]),
    .i_input_loop_active_n(st[2]), .i_input_supply_qualified(st[1]),
    .i_float_voltage_loop_flag(st[0]), .i_thermistor_out_of_range(oor),
    .i_charging(charging), .i_charge_done(done), .i_prod_mode(prod),
    .i_test_reg_value(test_val), .o_absent_detect(absent),
    .o_input_load_on(load_on), .o_background_charge_on(bg_on),
    .o_background_term_current(bg_term), .o_charge_current_cap(cap));
  // ---------------------------------------------------------------------
  // expectations and reporting
  // ---------------------------------------------------------------------
  function automatic logic exp_absent(input logic [1:0] pol);
    logic act;
    act = oor & (charging | done);
    case (pol)
      2'b00: return act;
      2'b01: return act & prod;
      2'b10: return act & (test_val !== CPM_TEST_KEY);
      default: return oor & charging;
    endcase
  endfunction : exp_absent
  function automatic logic [7:0] exp_len(input int c);
    case (c)
      1: return 8'h04;
      2: return 8'h08;
      3: return 8'h09;
      default: return 8'h00;
    endcase
  endfunction : exp_len
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    chk({4'h0, bg_on, bg_term}, CPM_POST_CFG_RST);
    u_host.rd(CPM_ADDR_POST_CFG, rd_v);
    chk(rd_v, CPM_POST_CFG_RST);
    u_host.wr(CPM_ADDR_MONITOR_A, 8'hFF);
    u_host.wr(8'h55, 8'hA5);
    u_host.rd(8'h55, rd_v);
    chk(rd_v, CPM_UNMAPPED_RD);
    u_host.rd(CPM_ADDR_POST_CFG, rd_v);
    chk(rd_v, CPM_POST_CFG_RST);
    for (n = 0; n < 48; n++) begin
      cfg = $random(seed);
      u_host.wr(CPM_ADDR_POST_CFG, cfg);
      chk({4'h0, bg_on, bg_term}, {4'h0, cfg[3:0]});
      u_host.rd(CPM_ADDR_POST_CFG, rd_v);
      chk(rd_v, cfg);
      @(negedge i_sys_clk);
      st = $random(seed);
      r = $random(seed);
      {oor, prod, charging} = r[2:0];
      done = ~r[0] & r[3];
      test_val = r[4] ? CPM_TEST_KEY : r[15:8];
      @(negedge i_sys_clk);
      chk(absent, exp_absent(cfg[7:6]));
      chk(cap, st[4]);
      u_host.rd(CPM_ADDR_MONITOR_A, rd_v);
      chk(rd_v, st);
    end
    @(negedge i_sys_clk);
    {done, charging, oor} = 3'b000;
    for (n = 0; n < 4; n++) begin
      u_host.wr(CPM_ADDR_POST_CFG, {2'b00, 2'(n), 4'h0});
      @(negedge i_sys_clk);
      done = 1'b1;
      cnt = 8'h00;
      repeat (20) begin
        @(negedge i_sys_clk);
        cnt = cnt + {7'h00, load_on === 1'b1};
      end
      chk(cnt, exp_len(n));
      chk(load_on, 8'h00);
      @(negedge i_sys_clk);
      chk(load_on, {7'h00, n != 0});
      done = 1'b0;
      repeat (2) @(negedge i_sys_clk);
      chk(load_on, 8'h00);
    end
    test_done();
  end
endmodule : charger_postcharge_monitor_regs_tb_top
`default_nettype wire
